// >>> shared/gpc_pkg.sv
package gpc_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int NPIN = 17;
	localparam int NLOW = 16;
	localparam int NCH = 4;

	// register offsets
	localparam logic [15:0] ADDR_IRQ_PENDING = 16'h4610;
	localparam logic [15:0] ADDR_IRQ_ENABLE = 16'h4628;
	localparam logic [15:0] ADDR_IRQ_A_CFG = 16'h4630;
	localparam logic [15:0] ADDR_IRQ_B_CFG = 16'h4632;
	localparam logic [15:0] ADDR_IRQ_C_CFG = 16'h4634;
	localparam logic [15:0] ADDR_IRQ_D_CFG = 16'h4636;
	localparam logic [15:0] ADDR_OE_HIGH = 16'h4714;
	localparam logic [15:0] ADDR_OE_LOW = 16'h4716;
	localparam logic [15:0] ADDR_OE_CLR_HIGH = 16'h471C;
	localparam logic [15:0] ADDR_OE_CLR_LOW = 16'h471E;
	localparam logic [15:0] ADDR_PD_HIGH = 16'h4720;
	localparam logic [15:0] ADDR_PD_LOW = 16'h4722;
	localparam logic [15:0] ADDR_PU_HIGH = 16'h4724;
	localparam logic [15:0] ADDR_PU_LOW = 16'h4726;
	localparam logic [15:0] ADDR_WAKE_LOW = 16'h4728;
	localparam logic [15:0] ADDR_WAKE_PENDING = 16'h4740;

	// channel config fields
	localparam int CFG_FILT_BIT = 8;
	localparam int CFG_MODE_LSB = 5;
	localparam int CFG_MODE_MSB = 7;

	// filter acceptance: input must hold this many cycles
	localparam logic [2:0] FILT_CYCLES = 3'h4;

	localparam logic [15:0] REG_RESET = 16'h0000;

	typedef enum logic [2:0]
	{
		TRIG_OFF = 3'b000,
		TRIG_RISE = 3'b001,
		TRIG_FALL = 3'b010,
		TRIG_BOTH = 3'b011,
		TRIG_HIGH = 3'b100,
		TRIG_LOW = 3'b101
	} gpc_trig_e;
endpackage : gpc_pkg

// >>> src/gpc_gpio.sv
// What this block does
// - writing one to bit 0 of high clear register clears pin 16 output enable
// - each one written to low clear register clears that pin's output enable
// - high pull-down bit 0 set turns on pin 16 pull-down
// - each set low pull-down bit turns on that pin's pull-down
// - high pull-up bit 0 set turns on pin 16 pull-up
// - each set wake bit watches that low pin for state change as wake source
// - four independent interrupt channels, config registers at consecutive even addresses
// - config bit 8 inserts input filter, clear bypasses it
// - trigger mode in bits 7:5, value 0 disables triggering
// - mode 1 rising, 2 falling, 3 both edges
// - mode 4 triggers while input high, mode 5 while input low
// - low output-enable bits drive output enables of pins 0 to 15
// - per-channel interrupt enable bits, channel A bit 0 to D bit 3
// - detected trigger sets channel pending flag, A bit 0 to D bit 3
//
// Strobed register access was left to the implementer.
module gpc_gpio
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [gpc_pkg::ADDR_W-1:0] bus_addr,
	input wire logic [gpc_pkg::DATA_W-1:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [gpc_pkg::DATA_W-1:0] bus_rdata,
	input wire logic [gpc_pkg::NPIN-1:0] gpio_in,
	input wire logic [gpc_pkg::NCH-1:0] ext_irq_in,
	output logic [gpc_pkg::NPIN-1:0] gpio_oe,
	output logic [gpc_pkg::NPIN-1:0] pulldown_en,
	output logic [gpc_pkg::NPIN-1:0] pullup_en,
	output logic irq,
	output logic wake_req
);
	import gpc_pkg::*;

	typedef struct packed
	{
		logic oe_high;
		logic [15:0] oe_low;
		logic pd_high;
		logic [15:0] pd_low;
		logic pu_high;
		logic [15:0] pu_low;
		logic [15:0] wake_en;
		logic [3:0] filt_en;
		logic [3:0][2:0] mode;
		logic [3:0] irq_en;
		logic [3:0] irq_pend;
		logic [15:0] wake_pend;
		logic [20:0] sync1;
		logic [20:0] sync2;
		logic [3:0] flt_lvl;
		logic [3:0][2:0] flt_cnt;
		logic [3:0] prev_lvl;
		logic [15:0] prev_pins;
		logic [15:0] rdata;
		logic irq_out;
		logic wake_out;
	} gpc_state_s;

	localparam gpc_state_s STATE_RST = '0;

	gpc_state_s state_reg;
	gpc_state_s state_next;
	logic [1:0] rst_sync_reg;
	logic rst_sync_n;

	////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [15:0] w1c(input logic [15:0] old, input logic [15:0] set,
		input logic [15:0] clr);
		// set wins over a clear in the same cycle
		w1c = (old & ~clr) | set;
	endfunction : w1c

	function automatic logic detect(input logic [2:0] mode, input logic cur, input logic prev);
		case (mode)
			TRIG_RISE: detect = cur & ~prev;
			TRIG_FALL: detect = ~cur & prev;
			TRIG_BOTH: detect = cur ^ prev;
			TRIG_HIGH: detect = cur;
			TRIG_LOW: detect = ~cur;
			// reserved codes treated as disabled
			default: detect = 1'b0;
		endcase
	endfunction : detect

	// channel index of a config address, 4 when not a config address
	function automatic logic [2:0] cfg_index(input logic [15:0] addr);
		if (addr == ADDR_IRQ_A_CFG)
			cfg_index = 3'h0;
		else if (addr == ADDR_IRQ_B_CFG)
			cfg_index = 3'h1;
		else if (addr == ADDR_IRQ_C_CFG)
			cfg_index = 3'h2;
		else if (addr == ADDR_IRQ_D_CFG)
			cfg_index = 3'h3;
		else
			cfg_index = 3'h4;
	endfunction : cfg_index

	////////////////////////////////////////////////////////////////////////
	// reset release

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	assign rst_sync_n = rst_sync_reg[1];

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		logic [3:0] chin;
		logic [3:0] trig;
		logic [15:0] wake_hit;
		logic [15:0] irq_clr;
		logic [15:0] wake_clr;
		logic [2:0] ci;
		logic [15:0] pend_all;
		chin = '0;
		pend_all = '0;
		trig = '0;
		wake_hit = '0;
		irq_clr = '0;
		wake_clr = '0;
		ci = cfg_index(bus_addr);
		state_next = state_reg;

		// pins and channel inputs come from outside: two flops first
		state_next.sync1 = {ext_irq_in, gpio_in};
		state_next.sync2 = state_reg.sync1;
		chin = state_reg.sync2[20:17];

		for (int i = 0; i < NCH; i++)
		begin
			if (!state_reg.filt_en[i])
			begin
				state_next.flt_lvl[i] = chin[i];
				state_next.flt_cnt[i] = 3'h0;
			end
			else if (chin[i] == state_reg.flt_lvl[i])
				state_next.flt_cnt[i] = 3'h0;
			else if (state_reg.flt_cnt[i] == FILT_CYCLES - 3'h1)
			begin
				state_next.flt_lvl[i] = chin[i];
				state_next.flt_cnt[i] = 3'h0;
			end
			else
				state_next.flt_cnt[i] = state_reg.flt_cnt[i] + 3'h1;
			trig[i] = detect(state_reg.mode[i], state_reg.flt_lvl[i], state_reg.prev_lvl[i]);
		end
		state_next.prev_lvl = state_reg.flt_lvl;

		// any change on a watched low pin is a wake event
		wake_hit = state_reg.wake_en & (state_reg.sync2[15:0] ^ state_reg.prev_pins);
		state_next.prev_pins = state_reg.sync2[15:0];

		if (bus_wr)
		begin
			if (bus_addr == ADDR_OE_HIGH)
				state_next.oe_high = bus_wdata[0];
			else if (bus_addr == ADDR_OE_LOW)
				state_next.oe_low = bus_wdata;
			else if (bus_addr == ADDR_OE_CLR_HIGH)
				state_next.oe_high = state_reg.oe_high & ~bus_wdata[0];
			else if (bus_addr == ADDR_OE_CLR_LOW)
				state_next.oe_low = state_reg.oe_low & ~bus_wdata;
			else if (bus_addr == ADDR_PD_HIGH)
				state_next.pd_high = bus_wdata[0];
			else if (bus_addr == ADDR_PD_LOW)
				state_next.pd_low = bus_wdata;
			else if (bus_addr == ADDR_PU_HIGH)
				state_next.pu_high = bus_wdata[0];
			else if (bus_addr == ADDR_PU_LOW)
				state_next.pu_low = bus_wdata;
			else if (bus_addr == ADDR_WAKE_LOW)
				state_next.wake_en = bus_wdata;
			else if (bus_addr == ADDR_WAKE_PENDING)
				wake_clr = bus_wdata;
			else if (bus_addr == ADDR_IRQ_ENABLE)
				state_next.irq_en = bus_wdata[3:0];
			else if (bus_addr == ADDR_IRQ_PENDING)
				irq_clr = bus_wdata;
			else if (ci != 3'h4)
			begin
				state_next.filt_en[ci[1:0]] = bus_wdata[CFG_FILT_BIT];
				state_next.mode[ci[1:0]] = bus_wdata[CFG_MODE_MSB:CFG_MODE_LSB];
			end
		end

		// channel flags share the 16-bit clear helper, upper bits unused
		pend_all = w1c({12'h000, state_reg.irq_pend}, {12'h000, trig}, irq_clr);
		state_next.irq_pend = pend_all[3:0];
		state_next.wake_pend = w1c(state_reg.wake_pend, wake_hit, wake_clr);
		state_next.irq_out = |(state_next.irq_pend & state_next.irq_en);
		state_next.wake_out = |state_next.wake_pend;

		// read data valid only in the cycle after the strobe
		state_next.rdata = 16'h0000;
		if (bus_rd)
		begin
			if (bus_addr == ADDR_OE_HIGH)
				state_next.rdata = {15'h0000, state_reg.oe_high};
			else if (bus_addr == ADDR_OE_LOW)
				state_next.rdata = state_reg.oe_low;
			else if (bus_addr == ADDR_PD_HIGH)
				state_next.rdata = {15'h0000, state_reg.pd_high};
			else if (bus_addr == ADDR_PD_LOW)
				state_next.rdata = state_reg.pd_low;
			else if (bus_addr == ADDR_PU_HIGH)
				state_next.rdata = {15'h0000, state_reg.pu_high};
			else if (bus_addr == ADDR_PU_LOW)
				state_next.rdata = state_reg.pu_low;
			else if (bus_addr == ADDR_WAKE_LOW)
				state_next.rdata = state_reg.wake_en;
			else if (bus_addr == ADDR_WAKE_PENDING)
				state_next.rdata = state_reg.wake_pend;
			else if (bus_addr == ADDR_IRQ_ENABLE)
				state_next.rdata = {12'h000, state_reg.irq_en};
			else if (bus_addr == ADDR_IRQ_PENDING)
				state_next.rdata = {12'h000, state_reg.irq_pend};
			else if (ci != 3'h4)
				state_next.rdata = {7'h00, state_reg.filt_en[ci[1:0]], state_reg.mode[ci[1:0]], 5'h00};
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			state_reg <= STATE_RST;
		else
			state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign bus_rdata = state_reg.rdata;
	assign gpio_oe = {state_reg.oe_high, state_reg.oe_low};
	assign pulldown_en = {state_reg.pd_high, state_reg.pd_low};
	assign pullup_en = {state_reg.pu_high, state_reg.pu_low};
	assign irq = state_reg.irq_out;
	assign wake_req = state_reg.wake_out;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_sync_n);

	chk_oe_high_clear: assert property (bus_wr && bus_addr == ADDR_OE_CLR_HIGH && bus_wdata[0] |=> !gpio_oe[16])
		else $error("pin 16 output enable not cleared");

	chk_oe_low_clear: assert property (bus_wr && bus_addr == ADDR_OE_CLR_LOW
		|=> gpio_oe[15:0] == ($past(gpio_oe[15:0]) & ~$past(bus_wdata)))
		else $error("low output enable clear wrong");

	chk_pd_high_on: assert property (bus_wr && bus_addr == ADDR_PD_HIGH |=> pulldown_en[16] == $past(bus_wdata[0]))
		else $error("pin 16 pull-down wrong");

	chk_pd_low_on: assert property (bus_wr && bus_addr == ADDR_PD_LOW |=> pulldown_en[15:0] == $past(bus_wdata))
		else $error("low pull-down wrong");

	chk_pu_high_on: assert property (bus_wr && bus_addr == ADDR_PU_HIGH |=> pullup_en[16] == $past(bus_wdata[0]))
		else $error("pin 16 pull-up wrong");

	chk_wake_pin_change: assert property (|(state_reg.wake_en & (state_reg.sync2[15:0] ^ state_reg.prev_pins))
		|=> wake_req)
		else $error("wake change not flagged");

	chk_cfg_b_write: assert property (bus_wr && bus_addr == ADDR_IRQ_B_CFG
		|=> state_reg.mode[1] == $past(bus_wdata[7:5]) && state_reg.filt_en[1] == $past(bus_wdata[8]))
		else $error("channel b config not stored");

	chk_filter_bypass: assert property (!state_reg.filt_en[0] |=> state_reg.flt_lvl[0] == $past(state_reg.sync2[17]))
		else $error("unfiltered input not passed");

	chk_mode_off: assert property (state_reg.mode[2] == TRIG_OFF && !state_reg.irq_pend[2] |=> !state_reg.irq_pend[2])
		else $error("disabled channel went pending");

	sequence s_rise_a;
		state_reg.mode[0] == TRIG_RISE ##0 state_reg.flt_lvl[0] && !state_reg.prev_lvl[0];
	endsequence

	sequence s_fall_b;
		state_reg.mode[1] == TRIG_FALL ##0 !state_reg.flt_lvl[1] && state_reg.prev_lvl[1];
	endsequence

	chk_rise_detect: assert property (s_rise_a |=> state_reg.irq_pend[0])
		else $error("rising edge missed");

	chk_fall_detect: assert property (s_fall_b |=> state_reg.irq_pend[1])
		else $error("falling edge missed");

	chk_level_low: assert property (state_reg.mode[3] == TRIG_LOW && !state_reg.flt_lvl[3]
		|=> state_reg.irq_pend[3] [*1] ##0 1'b1)
		else $error("low level not pending");

	chk_irq_line: assert property (irq == |(state_reg.irq_pend & state_reg.irq_en))
		else $error("interrupt line mismatch");

	chk_pend_stick: assert property (state_reg.irq_pend[0] && !(bus_wr && bus_addr == ADDR_IRQ_PENDING)
		|=> state_reg.irq_pend[0])
		else $error("pending flag lost");

	chk_filter_stable: assert property (state_reg.filt_en[0] && $past(state_reg.filt_en[0], 4)
		&& $changed(state_reg.flt_lvl[0])
		|-> $past(state_reg.sync2[17], 1) == state_reg.flt_lvl[0]
		&& $past(state_reg.sync2[17], 4) == state_reg.flt_lvl[0])
		else $error("filter accepted a glitch");

	// per-channel logic is shared, so one channel stands for all four below
	chk_oe_high_keep: assert property (bus_wr && bus_addr == ADDR_OE_CLR_HIGH && !bus_wdata[0]
		|=> $stable(gpio_oe[16]))
		else $error("pin 16 output enable changed by a zero write");

	chk_oe_low_drive: assert property (bus_wr && bus_addr == ADDR_OE_LOW
		|=> gpio_oe[15:0] == $past(bus_wdata))
		else $error("low output enables not driven");

	chk_pd_high_hold: assert property (!(bus_wr && bus_addr == ADDR_PD_HIGH) |=> $stable(pulldown_en[16]))
		else $error("pin 16 pull-down changed without a write");

	chk_pd_low_hold: assert property (!(bus_wr && bus_addr == ADDR_PD_LOW) |=> $stable(pulldown_en[15:0]))
		else $error("low pull-downs changed without a write");

	chk_pu_high_hold: assert property (!(bus_wr && bus_addr == ADDR_PU_HIGH) |=> $stable(pullup_en[16]))
		else $error("pin 16 pull-up changed without a write");

	chk_wake_quiet: assert property (state_reg.wake_en == 16'h0000 && !wake_req |=> !wake_req)
		else $error("wake raised with no pin watched");

	sequence s_both_c;
		state_reg.mode[2] == TRIG_BOTH ##0 state_reg.flt_lvl[2] != state_reg.prev_lvl[2];
	endsequence

	chk_both_detect: assert property (s_both_c |=> state_reg.irq_pend[2])
		else $error("either edge missed");

	chk_level_high: assert property (state_reg.mode[3] == TRIG_HIGH && state_reg.flt_lvl[3]
		|=> state_reg.irq_pend[3])
		else $error("high level not pending");

	chk_irq_masked: assert property (state_reg.irq_en == 4'h0 && !(bus_wr && bus_addr == ADDR_IRQ_ENABLE)
		|=> !irq)
		else $error("interrupt line high while all masked");

	chk_pend_clear: assert property (bus_wr && bus_addr == ADDR_IRQ_PENDING && bus_wdata[1]
		&& state_reg.mode[1] == TRIG_OFF |=> !state_reg.irq_pend[1])
		else $error("written one did not clear pending flag");

	sequence s_filt_ripe_a;
		state_reg.filt_en[0] && state_reg.flt_cnt[0] == FILT_CYCLES - 3'h1
		##0 state_reg.sync2[17] != state_reg.flt_lvl[0];
	endsequence

	chk_filter_accept: assert property (s_filt_ripe_a
		|=> state_reg.flt_lvl[0] == $past(state_reg.sync2[17]))
		else $error("held filter input not accepted");

	chk_filter_hold: assert property (state_reg.filt_en[0] && state_reg.flt_cnt[0] != FILT_CYCLES - 3'h1
		|=> $stable(state_reg.flt_lvl[0]))
		else $error("filter level moved too early");

	chk_cfg_d_write: assert property (bus_wr && bus_addr == ADDR_IRQ_D_CFG
		|=> state_reg.filt_en[3] == $past(bus_wdata[CFG_FILT_BIT])
		&& state_reg.mode[3] == $past(bus_wdata[CFG_MODE_MSB:CFG_MODE_LSB]))
		else $error("channel d config not stored");
endmodule : gpc_gpio

// >>> testbench/gpc_pin_model.sv
module gpc_pin_model
(
	input wire logic clk,
	input wire logic [16:0] drv,
	input wire logic [16:0] drv_en,
	input wire logic [16:0] pulldown_en,
	input wire logic [16:0] pullup_en,
	output logic [16:0] level
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [16:0] last_level = 17'h00000;
	////////////////////////////////////////////////////////////////
	// floating pins wander every cycle so nothing leans on a held value
	always @(posedge clk)
		last_level <= level;
	always @*
	begin
		for (int i = 0; i < 17; i++)
			level[i] = drv_en[i] ? drv[i] : pullup_en[i] ? 1'b1 : pulldown_en[i] ? 1'b0 : ~last_level[i];
	end
endmodule : gpc_pin_model

// >>> testbench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import gpc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic [15:0] bus_wdata = 16'h0000;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [3:0] ext_irq_in = 4'h0;
	logic [16:0] pin_drv = 17'h00000;
	logic [16:0] pin_en = 17'h1FFFF;
	wire logic [15:0] bus_rdata;
	wire logic [16:0] gpio_in, gpio_oe, pulldown_en, pullup_en;
	wire logic irq, wake_req;
	int miscompares = 0;
	int cmp_count = 0;
	localparam logic [15:0] REGS [17] = '{16'h4630, 16'h4632, 16'h4634, 16'h4636, 16'h4714, 16'h4716,
		16'h471C, 16'h471E, 16'h4720, 16'h4722, 16'h4724, 16'h4726, 16'h4728, 16'h4610, 16'h4628,
		16'h4740, 16'h4700};
	// last two edge cases: falling mode fed a rising edge, rising mode fed a falling edge
	localparam logic [2:0] MODE [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h2, 3'h1};
	localparam bit ST [8] = '{0, 1, 1, 0, 1, 0, 0, 1};
	localparam bit EXP [8] = '{1, 1, 1, 1, 1, 0, 0, 0};
	always #12.5 clk = ~clk;
	gpc_gpio dut (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .gpio_in(gpio_in), .ext_irq_in(ext_irq_in), .gpio_oe(gpio_oe),
		.pulldown_en(pulldown_en), .pullup_en(pullup_en), .irq(irq), .wake_req(wake_req));
	gpc_pin_model pins (.clk(clk), .drv(pin_drv), .drv_en(pin_en), .pulldown_en(pulldown_en),
		.pullup_en(pullup_en), .level(gpio_in));
	////////////////////////////////////////////////////////////////
	task automatic check(string name, logic [16:0] seen, logic [16:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			$display("unexpected %s expected %h seen %h", name, exp, seen);
			miscompares++;
		end
	endtask : check
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wr(logic [15:0] a, logic [15:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask : wr
	task automatic rdchk(string name, logic [15:0] a, logic [15:0] exp);
		@(posedge clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		check(name, {1'b0, bus_rdata}, {1'b0, exp});
	endtask : rdchk
	task automatic pulse(int w);
		@(posedge clk);
		ext_irq_in[0] <= 1'b1;
		repeat (w) @(posedge clk);
		ext_irq_in[0] <= 1'b0;
		tick(10);
	endtask : pulse
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5000) @(posedge clk);
		miscompares++;
		close_out();
	end
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (REGS[i]) rdchk("reset value", REGS[i], 16'h0000);
		wr(ADDR_OE_LOW, 16'hFFFF);
		wr(ADDR_OE_HIGH, 16'h0001);
		tick(2);
		check("oe all", gpio_oe, 17'h1FFFF);
		wr(ADDR_OE_CLR_LOW, 16'h00F0);
		wr(ADDR_OE_CLR_HIGH, 16'h0000);
		tick(2);
		check("oe clear low", gpio_oe, 17'h1FF0F);
		rdchk("oe low", ADDR_OE_LOW, 16'hFF0F);
		rdchk("clear low", ADDR_OE_CLR_LOW, 16'h0000);
		wr(ADDR_OE_CLR_HIGH, 16'hFFFF);
		tick(2);
		check("oe clear high", gpio_oe, 17'h0FF0F);
		wr(ADDR_PD_HIGH, 16'hFFFF);
		wr(ADDR_PD_LOW, 16'hA5A5);
		wr(ADDR_PU_HIGH, 16'h0001);
		wr(ADDR_PU_LOW, 16'h5A5A);
		tick(2);
		check("pulldown", pulldown_en, 17'h1A5A5);
		check("pullup", pullup_en, 17'h15A5A);
		rdchk("pd high", ADDR_PD_HIGH, 16'h0001);
		@(posedge clk);
		pin_drv[1] <= 1'b1;
		tick(6);
		check("wake unwatched", wake_req, 1'b0);
		wr(ADDR_WAKE_LOW, 16'h0001);
		@(posedge clk);
		pin_drv[0] <= 1'b1;
		tick(6);
		check("wake", wake_req, 1'b1);
		rdchk("wake pend", ADDR_WAKE_PENDING, 16'h0001);
		wr(ADDR_WAKE_PENDING, 16'h0001);
		tick(2);
		check("wake cleared", wake_req, 1'b0);
		// odd channels stay masked, so irq must stay low for them
		for (int ch = 0; ch < 4; ch++)
			for (int k = 0; k < 8; k++)
			begin
				@(posedge clk);
				ext_irq_in[ch] <= ST[k];
				wr(ADDR_IRQ_A_CFG + 16'(2 * ch), {8'h00, MODE[k], 5'h00});
				rdchk("cfg", ADDR_IRQ_A_CFG + 16'(2 * ch), {8'h00, MODE[k], 5'h00});
				wr(ADDR_IRQ_ENABLE, (ch % 2 == 0) ? 16'(1 << ch) : 16'h0000);
				tick(8);
				wr(ADDR_IRQ_PENDING, 16'h000F);
				@(posedge clk);
				ext_irq_in[ch] <= ~ST[k];
				tick(8);
				rdchk("pending", ADDR_IRQ_PENDING, EXP[k] ? 16'(1 << ch) : 16'h0000);
				check("irq", irq, EXP[k] && ch % 2 == 0);
			end
		wr(ADDR_IRQ_A_CFG, 16'h0120);
		wr(ADDR_IRQ_ENABLE, 16'h0001);
		tick(8);
		wr(ADDR_IRQ_PENDING, 16'h000F);
		pulse(3);
		rdchk("filtered glitch", ADDR_IRQ_PENDING, 16'h0000);
		pulse(6);
		rdchk("filtered pulse", ADDR_IRQ_PENDING, 16'h0001);
		wr(ADDR_IRQ_PENDING, 16'h000F);
		wr(ADDR_IRQ_A_CFG, 16'h0020);
		pulse(2);
		rdchk("bypassed glitch", ADDR_IRQ_PENDING, 16'h0001);
		check("irq set", irq, 1'b1);
		wr(ADDR_IRQ_PENDING, 16'h0001);
		tick(2);
		check("irq cleared", irq, 1'b0);
		close_out();
	end
endmodule : tb
